// [shared/ep1_params.svh]
// register offsets, field positions and reset values for the endpoint block
`ifndef EP1_PARAMS_SVH
`define EP1_PARAMS_SVH

// printed offsets are register indexes, not byte addresses: byte address is 4x
`define IDX_IN_CONFIG_HIGH   8'h12
`define IDX_OUT_CONTROL_LOW  8'h14
`define IDX_OUT_CONFIG_HIGH  8'h15
`define IDX_OUT_COUNT_LOW    8'h16
`define IDX_OUT_COUNT_HIGH   8'h17
`define IDX_INDEX            8'h0E
`define EP1_INDEX_VALUE      4'h1

`define BIT_DOUBLE_BUFFER    7
`define BIT_ISO              6
`define BIT_FORCE_TOGGLE     3

`define BIT_CLEAR_TOGGLE     7
`define BIT_SENT_STALL       6
`define BIT_SEND_STALL       5
`define BIT_FLUSH            4
`define BIT_DATA_ERROR       3
`define BIT_OVERRUN          2
`define BIT_FIFO_FULL        1
`define BIT_PACKET_READY     0

`define RESET_BYTE           8'h00
`define RESET_COUNT          10'h000

`endif

// [shared/ep1_pkg.sv]
// types shared by the endpoint block
package ep1_pkg;

    typedef struct packed {
        logic       valid;
        logic       crc_error;
        logic [9:0] length;
    } rx_packet_t;

    typedef struct packed {
        logic sent;
        logic acked;
    } in_event_t;

    typedef struct packed {
        logic stall;
        logic accept;
        logic discard;
        logic toggle;
    } out_answer_t;

    typedef enum logic [2:0] {
        slots_empty = 3'b001,
        slots_one   = 3'b010,
        slots_two   = 3'b100
    } slot_state_t;

endpackage

// [hw/usb_endpoint1_out_control.sv]
// endpoint1 out control, status and count logic with apb access
//
// Contract
// RULE1: in high byte bit 7 enables two in packet slots
// RULE2: out high byte bit 7 enables two out packet slots
// RULE3: bit 6 of each high byte selects isochronous, else bulk/interrupt
// RULE4: bulk and interrupt share identical hardware behaviour
// RULE5: force toggle set flips in toggle after every sent packet
// RULE6: force toggle clear flips in toggle only after ack
// RULE7: out interrupt on packet ready set and on stall sent
// RULE8: bulk packet received sets packet ready, interrupt, count shown
// RULE9: firmware unloads packet then writes zero to packet ready
// RULE10: send stall answers out with stall, sets sent stall, interrupts
// RULE11: send stall ignored in isochronous mode
// RULE12: double buffer second packet re-raises packet ready and interrupts
// RULE13: iso packet stored, packet ready set, interrupt raised
// RULE14: full fifo drops packet, sets overrun, interrupts
// RULE15: iso crc error still stored, ready set, data error set
// RULE16: data error cleared when software clears packet ready
// RULE17: clear toggle write resets out toggle; reads zero
// RULE18: flush drops next packet, clears ready, self clears
// RULE19: fifo full when slots used equal slots enabled
// RULE20: ten bit byte count split low and high, valid with ready
// RULE21: firmware should use double buffering for iso
// RULE22: unused bits read zero, writes ignored
// RULE23: registers mapped by the endpoint index register
// RULE24: reset clears all control, status and count bits
`timescale 1ns/1ps
`include "ep1_params.svh"

module usb_endpoint1_out_control
    import ep1_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire rx_packet_t  rx_packet,
    input  wire logic        out_token,
    input  wire in_event_t   in_event,
    output out_answer_t      out_answer,
    output logic             out_interrupt,
    output logic             in_toggle,
    output logic             in_double_buffer_enable,
    output logic             in_iso,
    output logic             out_double_buffer_enable,
    output logic             out_iso,
    output logic             fifo_reset
);

    ////////////////////////////////////////////////////////////////////
    // bus decode

    logic       wr_en;
    logic       rd_en;
    logic [7:0] reg_index;
    logic [7:0] wbyte;
    logic [3:0] ep_index;
    logic       ep1_sel;

    assign wr_en     = psel & penable & pwrite & pready & pstrb[0];
    assign rd_en     = psel & penable & ~pwrite & pready;
    assign reg_index = paddr[9:2];
    assign wbyte     = pwdata[7:0];
    assign ep1_sel   = (ep_index == `EP1_INDEX_VALUE);

    function automatic logic hit(input logic [7:0] idx);
        hit = wr_en & (reg_index == idx) & ep1_sel;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    logic        in_force_toggle;
    logic        send_stall;
    logic        sent_stall_flag;
    logic        overrun_flag;
    logic        data_error_flag;
    logic        out_packet_ready;
    logic        out_toggle;
    logic        flush_busy;
    logic [9:0]  count_first;
    logic [9:0]  count_second;
    logic        err_second;
    slot_state_t slots;
    logic        out_fifo_full;
    logic        stall_now;
    logic        rx_ok;
    logic        rx_drop;
    logic        sw_clear_ready;
    logic        pop;
    logic        ctl_wr;

    // bulk and interrupt never take separate paths
    assign stall_now = out_token & send_stall & ~out_iso; // RULE10 RULE11 RULE4
    assign out_fifo_full = out_double_buffer_enable ?
                           (slots == slots_two) :
                           (slots != slots_empty); // RULE19
    assign rx_ok   = rx_packet.valid & ~stall_now & ~out_fifo_full
                     & (out_iso | ~rx_packet.crc_error);
    assign rx_drop = rx_packet.valid & ~stall_now & out_fifo_full; // RULE14
    assign ctl_wr  = hit(`IDX_OUT_CONTROL_LOW);
    assign sw_clear_ready = ctl_wr & out_packet_ready
                            & ~wbyte[`BIT_PACKET_READY]; // RULE9
    assign pop = sw_clear_ready | (ctl_wr & wbyte[`BIT_FLUSH]
                 & (slots != slots_empty)); // RULE18

    ////////////////////////////////////////////////////////////////////
    // index register

    always_ff @(posedge mclk) begin
        if (srst) begin
            ep_index <= 4'h0;
        end else if (wr_en && reg_index == `IDX_INDEX) begin
            ep_index <= wbyte[3:0]; // RULE23
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration bytes

    always_ff @(posedge mclk) begin
        if (srst) begin
            in_double_buffer_enable <= 1'b0; // RULE24
            in_iso                  <= 1'b0;
            in_force_toggle         <= 1'b0;
        end else if (hit(`IDX_IN_CONFIG_HIGH)) begin
            in_double_buffer_enable <= wbyte[`BIT_DOUBLE_BUFFER]; // RULE1
            in_iso                  <= wbyte[`BIT_ISO]; // RULE3
            in_force_toggle         <= wbyte[`BIT_FORCE_TOGGLE];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            out_double_buffer_enable <= 1'b0;
            out_iso                  <= 1'b0;
        end else if (hit(`IDX_OUT_CONFIG_HIGH)) begin
            out_double_buffer_enable <= wbyte[`BIT_DOUBLE_BUFFER]; // RULE2
            out_iso                  <= wbyte[`BIT_ISO]; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////
    // in data toggle

    always_ff @(posedge mclk) begin
        if (srst) begin
            in_toggle <= 1'b0;
        end else if (in_event.sent && in_force_toggle) begin
            in_toggle <= ~in_toggle; // RULE5
        end else if (in_event.sent && in_event.acked) begin
            in_toggle <= ~in_toggle; // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////
    // send stall and sent stall flag

    always_ff @(posedge mclk) begin
        if (srst) begin
            send_stall <= 1'b0;
        end else if (ctl_wr) begin
            send_stall <= wbyte[`BIT_SEND_STALL];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            sent_stall_flag <= 1'b0;
        end else if (stall_now) begin
            sent_stall_flag <= 1'b1; // RULE10
        end else if (ctl_wr && !wbyte[`BIT_SENT_STALL]) begin
            sent_stall_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            overrun_flag <= 1'b0;
        end else if (rx_drop) begin
            overrun_flag <= 1'b1; // RULE14
        end else if (ctl_wr && !wbyte[`BIT_OVERRUN]) begin
            overrun_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // packet slots, ready flag and counts

    always_ff @(posedge mclk) begin
        if (srst) begin
            slots <= slots_empty;
        end else begin
            unique case (slots)
                slots_empty: if (rx_ok) slots <= slots_one;
                slots_one: begin
                    if (rx_ok && !pop) begin
                        slots <= slots_two; // RULE2
                    end else if (pop && !rx_ok) begin
                        slots <= slots_empty;
                    end
                end
                slots_two: if (pop) slots <= slots_one;
                default: slots <= slots_empty;
            endcase
        end
    end

    // second packet takes over the head on a pop
    always_ff @(posedge mclk) begin
        if (srst) begin
            count_first     <= `RESET_COUNT;
            count_second    <= `RESET_COUNT;
            err_second      <= 1'b0;
            data_error_flag <= 1'b0;
        end else begin
            if (rx_ok && (slots == slots_empty ||
                          (slots == slots_one && pop))) begin
                count_first     <= rx_packet.length; // RULE8 RULE20
                data_error_flag <= out_iso & rx_packet.crc_error; // RULE15
            end else if (rx_ok) begin
                count_second <= rx_packet.length;
                err_second   <= out_iso & rx_packet.crc_error;
            end else if (pop && slots == slots_two) begin
                count_first     <= count_second; // RULE12
                data_error_flag <= err_second;
            end else if (pop) begin
                data_error_flag <= 1'b0; // RULE16
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            out_packet_ready <= 1'b0;
        end else if (rx_ok) begin
            out_packet_ready <= 1'b1; // RULE8 RULE13
        end else if (pop) begin
            out_packet_ready <= (slots == slots_two); // RULE12 RULE18
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            flush_busy <= 1'b0;
            fifo_reset <= 1'b0;
        end else begin
            flush_busy <= ctl_wr & wbyte[`BIT_FLUSH]; // RULE18
            fifo_reset <= ctl_wr & wbyte[`BIT_FLUSH];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            out_toggle <= 1'b0;
        end else if (ctl_wr && wbyte[`BIT_CLEAR_TOGGLE]) begin
            out_toggle <= 1'b0; // RULE17
        end else if (rx_ok && !out_iso) begin
            out_toggle <= ~out_toggle;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link answers and interrupt

    always_ff @(posedge mclk) begin
        if (srst) begin
            out_answer    <= '0;
            out_interrupt <= 1'b0;
        end else begin
            out_answer.stall   <= stall_now;
            out_answer.accept  <= rx_ok;
            out_answer.discard <= rx_drop;
            out_answer.toggle  <= out_toggle;
            out_interrupt <= rx_ok | stall_now | rx_drop
                             | (pop && slots == slots_two); // RULE7 RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb read and ready

    logic [7:0] rbyte;

    always_comb begin
        rbyte = `RESET_BYTE;
        if (reg_index == `IDX_INDEX) begin
            rbyte = {4'h0, ep_index};
        end else if (ep1_sel) begin
            unique case (reg_index)
                `IDX_IN_CONFIG_HIGH: rbyte = {in_double_buffer_enable,
                    in_iso, 2'b00, in_force_toggle, 3'b000}; // RULE22
                `IDX_OUT_CONTROL_LOW: rbyte = {1'b0, sent_stall_flag,
                    send_stall, flush_busy, data_error_flag, overrun_flag,
                    out_fifo_full, out_packet_ready}; // RULE17
                `IDX_OUT_CONFIG_HIGH: rbyte = {out_double_buffer_enable,
                    out_iso, 6'b000000}; // RULE22
                `IDX_OUT_COUNT_LOW: rbyte = count_first[7:0]; // RULE20
                `IDX_OUT_COUNT_HIGH: rbyte = {6'b000000, count_first[9:8]};
                default: rbyte = `RESET_BYTE;
            endcase
        end
    end

    // no wait state: ready rises in the first access cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= {24'h000000, rbyte};
            pslverr <= 1'b0;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;

endmodule

// [bench/ep1_chk.sv]
// port assertions for the endpoint1 out control block
`timescale 1ns/1ps
module ep1_chk
    import ep1_pkg::*;
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire rx_packet_t  rx_packet,
    input wire logic        out_token,
    input wire in_event_t   in_event,
    input wire out_answer_t out_answer,
    input wire logic        out_interrupt,
    input wire logic        in_toggle,
    input wire logic        in_double_buffer_enable,
    input wire logic        in_iso,
    input wire logic        out_double_buffer_enable,
    input wire logic        out_iso,
    input wire logic        fifo_reset
);
////////////////////////////////////////////////////////////
default clocking @(posedge mclk); endclocking
default disable iff (srst);
logic wr_any;
logic wr_flush;
assign wr_any   = psel && penable && pready && pwrite && pstrb[0];
assign wr_flush = wr_any && paddr == 10'h050 && pwdata[4];
////////////////////////////////////////////////////////////
a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
a_no_error: assert property (!pslverr)
    else $error("slave error raised");
a_accept_cause: assert property (
    out_answer.accept |-> $past(rx_packet.valid))
    else $error("accept without packet");
a_accept_irq: assert property (out_answer.accept |-> out_interrupt)
    else $error("accept without interrupt");
a_stall_irq: assert property (
    out_answer.stall |-> out_interrupt && !$past(out_iso))
    else $error("stall wrong");
a_stall_cause: assert property (
    out_answer.stall |-> $past(out_token))
    else $error("stall without token");
a_ack_toggle: assert property (
    in_event.sent && in_event.acked |=> in_toggle != $past(in_toggle))
    else $error("in toggle not flipped on ack");
a_toggle_cause: assert property (
    $changed(in_toggle) |-> $past(in_event.sent))
    else $error("in toggle moved alone");
a_cfg_write: assert property (
    $changed(out_iso) || $changed(out_double_buffer_enable)
    |-> $past(wr_any))
    else $error("config moved without write");
a_flush_pulse: assert property (
    fifo_reset |-> $past(wr_flush) || $past(wr_flush, 2))
    else $error("fifo reset without flush");
a_drop_irq: assert property (
    out_answer.discard |-> out_interrupt && $past(rx_packet.valid))
    else $error("discard without packet or interrupt");
c_accept: cover property (out_answer.accept);
c_stall: cover property (out_answer.stall);
c_flush: cover property (fifo_reset);
c_drop: cover property (out_answer.discard);
endmodule

// [bench/usb_host_model.sv]
// host side model: out tokens, data packets and in events
`timescale 1ns/1ps
module usb_host_model
    import ep1_pkg::*;
(
    input  wire logic mclk,
    output rx_packet_t rx_packet,
    output logic       out_token,
    output in_event_t  in_event
);
initial begin
    rx_packet = '0;
    out_token = 1'b0;
    in_event  = '0;
end
task tok;
    @(posedge mclk); out_token <= 1'b1;
    @(posedge mclk); out_token <= 1'b0;
endtask
// data follows its token; length not held once the packet ends
task pkt(input logic [9:0] len, input logic crc);
    tok();
    rx_packet <= '{1'b1, crc, len};
    @(posedge mclk); rx_packet <= '{1'b0, 1'b0, ~len};
endtask
task ev(input logic ack);
    @(posedge mclk); in_event <= '{1'b1, ack};
    @(posedge mclk); in_event <= '0;
endtask
endmodule

// [bench/tb.sv]
// testbench for the endpoint1 out control block
`timescale 1ns/1ps
`include "ep1_params.svh"
`define CHK(s,e,g) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %s exp %h got %h", s, e, g); end end
module tb;
import ep1_pkg::*;
logic        mclk, srst, psel, penable, pwrite, pready, pslverr;
logic [9:0]  paddr;
logic [31:0] pwdata, prdata;
logic [3:0]  pstrb;
rx_packet_t  rx_packet;
in_event_t   in_event;
out_answer_t out_answer;
logic        out_token, out_interrupt, in_toggle, in_dbe, in_iso;
logic        out_dbe, out_iso, fifo_reset;
int          miscompares = 0, checked = 0, irqs = 0, n;
usb_endpoint1_out_control u_dut(.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_packet(rx_packet), .out_token(out_token), .in_event(in_event),
    .out_answer(out_answer), .out_interrupt(out_interrupt),
    .in_toggle(in_toggle), .in_double_buffer_enable(in_dbe),
    .in_iso(in_iso), .out_double_buffer_enable(out_dbe),
    .out_iso(out_iso), .fifo_reset(fifo_reset));
usb_host_model h(.mclk(mclk), .rx_packet(rx_packet),
    .out_token(out_token), .in_event(in_event));
initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
end
always @(posedge mclk) if (out_interrupt === 1'b1) irqs <= irqs + 1;
////////////////////////////////////////////////////////////
task rw(input logic w, input logic [7:0] i, input logic [7:0] d,
        output logic [7:0] q);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
    pstrb <= {4{w}};
    @(posedge mclk); penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 1'b0; penable <= 1'b0;
endtask
task wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    rw(1'b1, i, d, q);
endtask
task rdc(input logic [7:0] i, input logic [7:0] e, input string s);
    logic [7:0] q;
    rw(1'b0, i, 8'h00, q);
    `CHK(s, e, q)
endtask
task pause;
    repeat (2) @(posedge mclk);
endtask
task print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
        $display("STATUS OK");
    end else begin
        $display("STATUS NOT OK");
    end
    $finish;
endtask
initial begin
    #2000000;
    miscompares++;
    print_verdict();
end
////////////////////////////////////////////////////////////
initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = 4'h0; // lanes set on writes only
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    wr(8'h12, 8'hC8);
    wr(`IDX_INDEX, {4'h0, `EP1_INDEX_VALUE});
    rdc(8'h12, 8'h00, "unmapped write");
    for (int k = 0; k < 4; k++) rdc(8'h14 + 8'(k), 8'h00, "reset");
    rdc(8'h13, 8'h00, "gap");
    $display("test reset done");
    wr(8'h12, 8'hFF); rdc(8'h12, 8'hC8, "in cfg");
    `CHK("in dbe", 1'b1, in_dbe)
    `CHK("in iso", 1'b1, in_iso)
    wr(8'h15, 8'hFF); rdc(8'h15, 8'hC0, "out cfg");
    `CHK("out iso", 1'b1, out_iso)
    `CHK("out dbe", 1'b1, out_dbe)
    wr(8'h15, 8'h00); wr(8'h12, 8'h08);
    h.ev(1'b0); pause(); `CHK("force tgl", 1'b1, in_toggle)
    wr(8'h12, 8'h00);
    h.ev(1'b0); pause(); `CHK("nak tgl", 1'b1, in_toggle)
    h.ev(1'b1); pause(); `CHK("ack tgl", 1'b0, in_toggle)
    $display("test config done");
    h.pkt(10'h2A5, 1'b0); rdc(8'h14, 8'h03, "bulk");
    rdc(8'h16, 8'hA5, "cnt lo");
    rdc(8'h17, 8'h02, "cnt hi");
    wr(8'h14, 8'h00); rdc(8'h14, 8'h00, "pop");
    wr(8'h15, 8'h80); n = irqs;
    h.pkt(10'h005, 1'b0); h.pkt(10'h006, 1'b0);
    rdc(8'h14, 8'h03, "db full");
    wr(8'h14, 8'h00); rdc(8'h14, 8'h01, "db again");
    rdc(8'h16, 8'h06, "db cnt");
    `CHK("db irqs", 3, irqs - n)
    wr(8'h14, 8'h00); wr(8'h15, 8'h00);
    $display("test bulk done");
    wr(8'h14, 8'h20); n = irqs;
    h.tok(); rdc(8'h14, 8'h60, "stall");
    `CHK("stall irq", 1, irqs - n)
    wr(8'h14, 8'h20); rdc(8'h14, 8'h20, "stall clr");
    wr(8'h15, 8'hC0);
    h.tok(); rdc(8'h14, 8'h20, "iso stall");
    wr(8'h14, 8'h00);
    h.pkt(10'h010, 1'b1); rdc(8'h14, 8'h09, "iso err");
    h.pkt(10'h011, 1'b0); h.pkt(10'h012, 1'b0);
    rdc(8'h14, 8'h0F, "overrun");
    wr(8'h14, 8'h00); rdc(8'h14, 8'h01, "iso next");
    wr(8'h14, 8'h00); rdc(8'h14, 8'h00, "iso pop");
    $display("test iso done");
    wr(8'h15, 8'h00); h.pkt(10'h003, 1'b0);
    wr(8'h14, 8'h11); pause(); rdc(8'h14, 8'h00, "flush");
    h.pkt(10'h004, 1'b0); pause();
    `CHK("tgl flip", 1'b1, out_answer.toggle)
    wr(8'h14, 8'h80); rdc(8'h14, 8'h00, "clr tgl rd");
    `CHK("out tgl", 1'b0, out_answer.toggle)
    $display("test flush done");
    wr(8'h15, 8'h80); h.pkt(10'h007, 1'b0);
    @(posedge mclk) srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    wr(`IDX_INDEX, {4'h0, `EP1_INDEX_VALUE});
    rdc(8'h14, 8'h00, "rst ctl");
    rdc(8'h15, 8'h00, "rst cfg");
    rdc(8'h16, 8'h00, "rst cnt");
    `CHK("rst tgl", 1'b0, out_answer.toggle)
    $display("test reset again done");
    print_verdict();
end
endmodule
bind usb_endpoint1_out_control ep1_chk u_chk(.mclk(mclk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_packet(rx_packet), .out_token(out_token),
    .in_event(in_event), .out_answer(out_answer),
    .out_interrupt(out_interrupt), .in_toggle(in_toggle),
    .in_double_buffer_enable(in_double_buffer_enable), .in_iso(in_iso),
    .out_double_buffer_enable(out_double_buffer_enable),
    .out_iso(out_iso), .fifo_reset(fifo_reset));
